// *** core/awgtr_consts.svh ***
// Contract
// - trigger mode selects external, software, pulse, OR/AND combination or delayed trigger.
// - active trigger edge programmable as rising, falling or both edges.
// - pulse width programmable 0 to 4G-1 samples in one-sample steps.
// - trigger delay programmable 0 to 4G-1 sample clocks in one-sample steps.
// - multi and gate modes ignore triggers during holdoff of 0 to 4G-1 samples.
// - multi and gate modes re-arm under 24 clocks after segment end plus holdoff.
// - waveform output starts fixed 63 sample clocks after the accepted trigger.
// - memory depth 16 up to installed memory per active channel, steps of 8.
// - multi segment size 8 up to installed memory per active channel, steps of 8.
// - external trigger resolved to within one sample clock period.
// - three multi-purpose logic lines also act as trigger sources.
// - 16-bit samples go to the converter at sample rate, no interpolation.
// - amplitudes below 300 mV are made by digital scaling of samples.
// - output disabled for about 1.2 ms when amplifier path changes.
// - one of four reconstruction filters selectable per output.
`ifndef AWGTR_CONSTS_SVH
`define AWGTR_CONSTS_SVH

// ***********************************************
// register byte offsets
// ***********************************************
`define AWGTR_OFS_CTRL     8'h00
`define AWGTR_OFS_CMD      8'h04
`define AWGTR_OFS_PULSE    8'h08
`define AWGTR_OFS_DELAY    8'h0C
`define AWGTR_OFS_HOLDOFF  8'h10
`define AWGTR_OFS_MEMSIZE  8'h14
`define AWGTR_OFS_SEGSIZE  8'h18
`define AWGTR_OFS_AMPL     8'h1C
`define AWGTR_OFS_STATUS   8'h20

// ***********************************************
// field positions
// ***********************************************
`define AWGTR_CTRL_MODE_LSB   0
`define AWGTR_CTRL_EDGE_LSB   3
`define AWGTR_CTRL_SRC_LSB    5
`define AWGTR_CTRL_REPLAY_LSB 9
`define AWGTR_CTRL_FILT_LSB   11
`define AWGTR_CTRL_CHAN_LSB   13
`define AWGTR_CMD_FORCE       0
`define AWGTR_CMD_ARM         1
`define AWGTR_CMD_STOP        2
`define AWGTR_CMD_CLR_ERR     3
`define AWGTR_STAT_ERR        3
`define AWGTR_STAT_OUTEN      4
`define AWGTR_STAT_PATH       5
`define AWGTR_STAT_CNT_LSB    16

// ***********************************************
// reset values and limits
// ***********************************************
`define AWGTR_RST_MEMSIZE  32'h0000_0010
`define AWGTR_RST_SEGSIZE  32'h0000_0008
`define AWGTR_RST_AMPL     13'h03E8
`define AWGTR_MEM_MIN      32'h0000_0010
`define AWGTR_SEG_MIN      32'h0000_0008
`define AWGTR_SIZE_STEP    32'h0000_0008
`define AWGTR_INSTALLED    32'h0100_0000

// ***********************************************
// amplitude handling
// ***********************************************
`define AWGTR_SCALE_MV     13'h012C
`define AWGTR_PATH_UP_MV   13'h03C0
`define AWGTR_PATH_DN_MV   13'h03AC
`define AWGTR_SCALE_RECIP  17'h000DA
`define AWGTR_GAIN_UNITY   17'h10000

// ***********************************************
// timing
// ***********************************************
`define AWGTR_CLK_MHZ        250
`define AWGTR_TRIG_LAT       63
`define AWGTR_PIPE_STAGES    2
`define AWGTR_REARM_MAX      24
`define AWGTR_SWITCH_TIME_NS 1200000
`define AWGTR_SWITCH_CYC     ((`AWGTR_SWITCH_TIME_NS * `AWGTR_CLK_MHZ + 999) / 1000)

`endif

// *** core/awgtr_pkg.sv ***
package awgtr_pkg;

    typedef enum logic [2:0] {
        AWGTR_TM_EXT,
        AWGTR_TM_SOFT,
        AWGTR_TM_PULSE,
        AWGTR_TM_OR,
        AWGTR_TM_AND,
        AWGTR_TM_DELAY
    } awgtr_tmode_t;

    typedef enum logic [1:0] {
        AWGTR_EDGE_RISE,
        AWGTR_EDGE_FALL,
        AWGTR_EDGE_BOTH
    } awgtr_edge_t;

    typedef enum logic [1:0] {
        AWGTR_RP_SINGLE,
        AWGTR_RP_MULTI,
        AWGTR_RP_GATE
    } awgtr_replay_t;

    typedef enum logic [2:0] {
        AWGTR_ST_IDLE,
        AWGTR_ST_ARMED,
        AWGTR_ST_WAIT,
        AWGTR_ST_RUN,
        AWGTR_ST_REARM
    } awgtr_state_t;

    typedef struct packed {
        awgtr_tmode_t  tmode;
        awgtr_edge_t   edge_sel;
        logic [3:0]    src_en;
        awgtr_replay_t replay;
        logic [1:0]    filt;
        logic [1:0]    chan_log2;
    } awgtr_cfg_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } awgtr_bus_t;

endpackage

// *** core/awgtr_qual.sv ***
`timescale 1ns/1ps
`include "awgtr_consts.svh"

// edge / pulse-width qualifier on an already synchronised level
module awgtr_qual
    import awgtr_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        level_i,
    input  awgtr_edge_t      edge_sel_i,
    input  wire logic        pulse_mode_i,
    input  wire logic [31:0] width_i,
    output logic             event_o,
    output logic             active_o
);

    logic        prev_q;
    logic [31:0] run_q;
    logic [31:0] run_d;
    logic [31:0] target;
    logic        rise;
    logic        fall;
    logic        act;
    logic        edge_hit;

    assign rise   = level_i & ~prev_q;
    assign fall   = ~level_i & prev_q;
    // width 0 behaves as width 1: the edge itself qualifies
    assign target = (width_i == 32'h0000_0000) ? 32'h0000_0001 : width_i;

    assign act      = (edge_sel_i == AWGTR_EDGE_RISE) ? level_i :
                      (edge_sel_i == AWGTR_EDGE_FALL) ? ~level_i : 1'b1;
    assign edge_hit = (edge_sel_i == AWGTR_EDGE_RISE) ? rise :
                      (edge_sel_i == AWGTR_EDGE_FALL) ? fall : (rise | fall);

    // saturating run length of the current level, so one long pulse fires once
    assign run_d = (level_i != prev_q) ? 32'h0000_0001 :
                   (run_q == 32'hFFFF_FFFF) ? run_q : run_q + 32'h0000_0001;

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            prev_q <= 1'b0;
            run_q  <= 32'h0000_0000;
        end
        else
        begin
            prev_q <= level_i;
            run_q  <= run_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            event_o  <= 1'b0;
            active_o <= 1'b0;
        end
        else
        begin
            if (pulse_mode_i)
                event_o <= act && (run_d == target);
            else
                event_o <= edge_hit;
            active_o <= act & (edge_sel_i != AWGTR_EDGE_BOTH ? 1'b1 : level_i);
        end
    end

endmodule

// *** core/awgtr_top.sv ***
`timescale 1ns/1ps
`include "awgtr_consts.svh"

module awgtr_top
    import awgtr_pkg::*;
#(
    parameter int unsigned SWITCH_CYC = `AWGTR_SWITCH_CYC,
    parameter logic [31:0] INSTALLED  = `AWGTR_INSTALLED
)
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [31:0]      reg_rdata_o,
    input  wire logic        trig_cmp_i,
    input  wire logic        multipurpose_line_one_i,
    input  wire logic        multipurpose_line_two_i,
    input  wire logic        multipurpose_line_three_i,
    output logic [31:0]      mem_addr_o,
    output logic             mem_rd_o,
    input  wire logic [15:0] mem_data_i,
    output logic [15:0]      dac_data_o,
    output logic             dac_valid_o,
    output logic             out_en_o,
    output logic             amp_path_o,
    output logic [1:0]       filt_sel_o,
    output logic             running_o
);

    // ***********************************************
    // helpers
    // ***********************************************
    function automatic logic size_ok(input logic [31:0] v, input logic [31:0] lo, input logic [1:0] cl2);
        size_ok = (v >= lo) && (v[2:0] == 3'h0) && (v <= (INSTALLED >> cl2));
    endfunction

    function automatic logic [31:0] cnt_dec(input logic [31:0] v);
        cnt_dec = (v == 32'h0000_0000) ? v : v - 32'h0000_0001;
    endfunction

    // ***********************************************
    // registers
    // ***********************************************
    awgtr_bus_t   bus;
    awgtr_cfg_t   cfg_q;
    awgtr_state_t state_q;
    logic [31:0]  pulse_q;
    logic [31:0]  delay_q;
    logic [31:0]  holdoff_q;
    logic [31:0]  memsize_q;
    logic [31:0]  segsize_q;
    logic [12:0]  ampl_q;
    logic [16:0]  gain_q;
    logic         err_q;
    logic [15:0]  trig_cnt_q;
    logic         wr_cmd;
    logic         force_trig;
    logic         bad_size;

    assign bus        = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
    assign wr_cmd     = bus.wr && (bus.addr == `AWGTR_OFS_CMD);
    assign force_trig = wr_cmd && bus.wdata[`AWGTR_CMD_FORCE];
    assign bad_size   = bus.wr &&
        (((bus.addr == `AWGTR_OFS_MEMSIZE) && !size_ok(bus.wdata, `AWGTR_MEM_MIN, cfg_q.chan_log2)) ||
         ((bus.addr == `AWGTR_OFS_SEGSIZE) && !size_ok(bus.wdata, `AWGTR_SEG_MIN, cfg_q.chan_log2)));

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cfg_q     <= '{tmode: AWGTR_TM_EXT, edge_sel: AWGTR_EDGE_RISE, src_en: 4'h1,
                           replay: AWGTR_RP_SINGLE, filt: 2'h0, chan_log2: 2'h0};
            pulse_q   <= 32'h0000_0000;
            delay_q   <= 32'h0000_0000;
            holdoff_q <= 32'h0000_0000;
            memsize_q <= `AWGTR_RST_MEMSIZE;
            segsize_q <= `AWGTR_RST_SEGSIZE;
            ampl_q    <= `AWGTR_RST_AMPL;
        end
        else if (bus.wr)
        begin
            unique case (bus.addr)
                `AWGTR_OFS_CTRL:
                begin
                    // illegal mode codes leave the previous setting in place
                    if (bus.wdata[`AWGTR_CTRL_MODE_LSB +: 3] <= 3'h5)
                        cfg_q.tmode <= awgtr_tmode_t'(bus.wdata[`AWGTR_CTRL_MODE_LSB +: 3]);
                    if (bus.wdata[`AWGTR_CTRL_EDGE_LSB +: 2] != 2'h3)
                        cfg_q.edge_sel <= awgtr_edge_t'(bus.wdata[`AWGTR_CTRL_EDGE_LSB +: 2]);
                    if (bus.wdata[`AWGTR_CTRL_REPLAY_LSB +: 2] != 2'h3)
                        cfg_q.replay <= awgtr_replay_t'(bus.wdata[`AWGTR_CTRL_REPLAY_LSB +: 2]);
                    cfg_q.src_en    <= bus.wdata[`AWGTR_CTRL_SRC_LSB +: 4];
                    cfg_q.filt      <= bus.wdata[`AWGTR_CTRL_FILT_LSB +: 2];
                    cfg_q.chan_log2 <= bus.wdata[`AWGTR_CTRL_CHAN_LSB +: 2];
                end
                `AWGTR_OFS_PULSE:   pulse_q   <= bus.wdata;
                `AWGTR_OFS_DELAY:   delay_q   <= bus.wdata;
                `AWGTR_OFS_HOLDOFF: holdoff_q <= bus.wdata;
                `AWGTR_OFS_MEMSIZE: if (!bad_size) memsize_q <= bus.wdata;
                `AWGTR_OFS_SEGSIZE: if (!bad_size) segsize_q <= bus.wdata;
                `AWGTR_OFS_AMPL:    ampl_q    <= bus.wdata[12:0];
                default: ;
            endcase
        end
    end

    // rejected size writes set the error; set wins over a same-cycle clear
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            err_q <= 1'b0;
        else if (bad_size)
            err_q <= 1'b1;
        else if (wr_cmd && bus.wdata[`AWGTR_CMD_CLR_ERR])
            err_q <= 1'b0;
    end

    // ***********************************************
    // trigger inputs
    // ***********************************************
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] en_lv;
    logic       comb_lv;
    logic       qual_ev;
    logic       gate_act;

    // two stages per pin; one clock of input skew is the resolution
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end
        else
        begin
            sync1_q <= {multipurpose_line_three_i, multipurpose_line_two_i,
                        multipurpose_line_one_i, trig_cmp_i};
            sync2_q <= sync1_q;
        end
    end

    assign en_lv = sync2_q & cfg_q.src_en;

    always_comb
    begin
        unique case (cfg_q.tmode)
            AWGTR_TM_EXT, AWGTR_TM_DELAY: comb_lv = sync2_q[0];
            AWGTR_TM_SOFT:                comb_lv = 1'b0;
            AWGTR_TM_AND:                 comb_lv = (cfg_q.src_en != 4'h0) && (en_lv == cfg_q.src_en);
            default:                      comb_lv = |en_lv;
        endcase
    end

    awgtr_qual awgtr_qual_inst (
        .ref_clk_i    (ref_clk_i),
        .rst_b_i      (rst_b_i),
        .level_i      (comb_lv),
        .edge_sel_i   (cfg_q.edge_sel),
        .pulse_mode_i (cfg_q.tmode == AWGTR_TM_PULSE),
        .width_i      (pulse_q),
        .event_o      (qual_ev),
        .active_o     (gate_act)
    );

    // ***********************************************
    // replay sequencer
    // ***********************************************
    logic [32:0] wait_q;
    logic [31:0] hold_q;
    logic [31:0] left_q;
    logic [31:0] played_q;
    logic [31:0] addr_q;
    logic        accept;
    logic        seg_end;
    logic        stop;

    assign accept  = (state_q == AWGTR_ST_ARMED) && (force_trig || (qual_ev && cfg_q.tmode != AWGTR_TM_SOFT));
    assign seg_end = (cfg_q.replay == AWGTR_RP_GATE) ? !gate_act : (left_q == 32'h0000_0001);
    assign stop    = wr_cmd && bus.wdata[`AWGTR_CMD_STOP];

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_q  <= AWGTR_ST_IDLE;
            wait_q   <= 33'h0_0000_0000;
            hold_q   <= 32'h0000_0000;
            left_q   <= 32'h0000_0000;
            played_q <= 32'h0000_0000;
            addr_q   <= 32'h0000_0000;
        end
        else if (stop)
            state_q <= AWGTR_ST_IDLE;
        else
        begin
            unique case (state_q)
                AWGTR_ST_IDLE:
                    if (wr_cmd && bus.wdata[`AWGTR_CMD_ARM])
                    begin
                        state_q  <= AWGTR_ST_ARMED;
                        addr_q   <= 32'h0000_0000;
                        played_q <= 32'h0000_0000;
                    end
                AWGTR_ST_ARMED:
                    if (accept)
                    begin
                        // load edge and pipeline stages are part of the fixed latency
                        state_q <= AWGTR_ST_WAIT;
                        wait_q  <= 33'(`AWGTR_TRIG_LAT - `AWGTR_PIPE_STAGES - 2) +
                                   ((cfg_q.tmode == AWGTR_TM_DELAY) ? {1'b0, delay_q} : 33'h0_0000_0000);
                    end
                AWGTR_ST_WAIT:
                    if (wait_q == 33'h0_0000_0000)
                    begin
                        state_q <= AWGTR_ST_RUN;
                        left_q  <= (cfg_q.replay == AWGTR_RP_MULTI) ? segsize_q : memsize_q;
                    end
                    else
                        wait_q <= wait_q - 33'h0_0000_0001;
                AWGTR_ST_RUN:
                begin
                    addr_q   <= (addr_q + 32'h0000_0001 >= memsize_q) ? 32'h0000_0000 : addr_q + 32'h0000_0001;
                    left_q   <= cnt_dec(left_q);
                    played_q <= played_q + 32'h0000_0001;
                    if (seg_end)
                    begin
                        hold_q <= holdoff_q;
                        if (cfg_q.replay == AWGTR_RP_SINGLE ||
                            (cfg_q.replay == AWGTR_RP_MULTI && played_q + 32'h0000_0001 >= memsize_q))
                            state_q <= AWGTR_ST_IDLE;
                        else
                            state_q <= AWGTR_ST_REARM;
                    end
                end
                AWGTR_ST_REARM:
                    // triggers are not looked at until armed again
                    if (hold_q == 32'h0000_0000)
                        state_q <= AWGTR_ST_ARMED;
                    else
                        hold_q <= cnt_dec(hold_q);
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            trig_cnt_q <= 16'h0000;
        else if (accept)
            trig_cnt_q <= trig_cnt_q + 16'h0001;
    end

    // ***********************************************
    // sample path
    // ***********************************************
    logic signed [33:0] prod;

    // reciprocal of 300 keeps the multiplier the only arithmetic on the data path
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            gain_q <= `AWGTR_GAIN_UNITY;
        else if (ampl_q < `AWGTR_SCALE_MV)
            gain_q <= 17'(ampl_q * `AWGTR_SCALE_RECIP);
        else
            gain_q <= `AWGTR_GAIN_UNITY;
    end

    assign prod = $signed(mem_data_i) * $signed({1'b0, gain_q});

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mem_rd_o    <= 1'b0;
            mem_addr_o  <= 32'h0000_0000;
            dac_valid_o <= 1'b0;
            dac_data_o  <= 16'h0000;
        end
        else
        begin
            mem_rd_o    <= (state_q == AWGTR_ST_RUN);
            mem_addr_o  <= addr_q;
            dac_valid_o <= mem_rd_o;
            dac_data_o  <= prod[31:16];
        end
    end

    // ***********************************************
    // amplifier path and muting
    // ***********************************************
    logic        path_d;
    logic [31:0] mute_q;

    // 940/960 hysteresis avoids chattering between paths
    assign path_d = amp_path_o ? (ampl_q > `AWGTR_PATH_DN_MV) : (ampl_q >= `AWGTR_PATH_UP_MV);

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            amp_path_o <= 1'b1;
            mute_q     <= 32'h0000_0000;
            out_en_o   <= 1'b1;
        end
        else
        begin
            amp_path_o <= path_d;
            if (path_d != amp_path_o)
                mute_q <= SWITCH_CYC;
            else
                mute_q <= cnt_dec(mute_q);
            out_en_o <= (path_d == amp_path_o) && (mute_q <= 32'h0000_0001);
        end
    end

    // ***********************************************
    // outputs and readback
    // ***********************************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            filt_sel_o  <= 2'h0;
            running_o   <= 1'b0;
            reg_rdata_o <= 32'h0000_0000;
        end
        else
        begin
            filt_sel_o <= cfg_q.filt;
            running_o  <= (state_q == AWGTR_ST_RUN);
            if (bus.rd)
            begin
                unique case (bus.addr)
                    `AWGTR_OFS_CTRL:    reg_rdata_o <= {17'h00000, cfg_q.chan_log2, cfg_q.filt, cfg_q.replay,
                                                        cfg_q.src_en, cfg_q.edge_sel, cfg_q.tmode};
                    `AWGTR_OFS_PULSE:   reg_rdata_o <= pulse_q;
                    `AWGTR_OFS_DELAY:   reg_rdata_o <= delay_q;
                    `AWGTR_OFS_HOLDOFF: reg_rdata_o <= holdoff_q;
                    `AWGTR_OFS_MEMSIZE: reg_rdata_o <= memsize_q;
                    `AWGTR_OFS_SEGSIZE: reg_rdata_o <= segsize_q;
                    `AWGTR_OFS_AMPL:    reg_rdata_o <= {19'h00000, ampl_q};
                    `AWGTR_OFS_STATUS:  reg_rdata_o <= {trig_cnt_q, 10'h000, amp_path_o, out_en_o, err_q, state_q};
                    default:            reg_rdata_o <= 32'h0000_0000;
                endcase
            end
            else
                reg_rdata_o <= 32'h0000_0000;
        end
    end

endmodule

// *** sim/awgtr_props.sv ***
`timescale 1ns/1ps
// ********
// port checks of the trigger and replay block
// ********
module awgtr_props
#(
    parameter int unsigned SWITCH_CYC = 20
)
(
    input wire logic        ref_clk_i,
    input wire logic        rst_b_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        mem_rd_o,
    input wire logic        dac_valid_o,
    input wire logic        out_en_o,
    input wire logic        amp_path_o,
    input wire logic [1:0]  filt_sel_o,
    input wire logic        running_o
);
    logic [31:0] mute_q;

    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // switch time is far too long to unroll, so it is counted
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            mute_q <= '0;
        else
            mute_q <= out_en_o ? '0 : mute_q + 32'h1;
    end

    chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside its slot");
    chk_cmd_reads_zero: assert property (reg_rd_i && reg_addr_i == 8'h04 |=> reg_rdata_o == 32'h0)
        else $error("command word read back");
    chk_filt_copy: assert property (reg_wr_i && reg_addr_i == 8'h00 |=> ##1 filt_sel_o == $past(reg_wdata_i[12:11], 2))
        else $error("filter select not updated");
    chk_mute_start: assert property ($changed(amp_path_o) |=> !out_en_o)
        else $error("output live during path switch");
    chk_mute_length: assert property ($rose(out_en_o) |-> mute_q == SWITCH_CYC)
        else $error("wrong mute length");
    chk_valid_after_read: assert property (mem_rd_o |=> dac_valid_o)
        else $error("sample missing after memory read");
    chk_valid_has_cause: assert property (dac_valid_o |-> $past(mem_rd_o))
        else $error("sample without memory read");
    chk_run_before_read: assert property ($rose(mem_rd_o) |-> running_o)
        else $error("replay outside run state");
    chk_stop_halts: assert property (reg_wr_i && reg_addr_i == 8'h04 && reg_wdata_i[2] |=> ##1 !mem_rd_o)
        else $error("replay continues after stop");

    cov_replay: cover property ($rose(dac_valid_o));
    cov_path_switch: cover property ($changed(amp_path_o));
    cov_read: cover property (reg_rd_i ##1 reg_rdata_o != 32'h0);
endmodule

bind awgtr_top awgtr_props #(.SWITCH_CYC(SWITCH_CYC)) awgtr_props_inst (
    .ref_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .mem_rd_o, .dac_valid_o, .out_en_o, .amp_path_o, .filt_sel_o, .running_o);

// *** sim/awgtr_trig_src.sv ***
`timescale 1ns/1ps
// ********
// comparator and logic line source
// ********
module awgtr_trig_src
(
    output logic [3:0] lines_o,
    input  wire logic  ref_clk_i
);
    initial lines_o = 4'h0;

    task automatic pulse(input logic [3:0] mask, input int len);
        @(posedge ref_clk_i);
        lines_o <= mask;
        repeat ((len < 2) ? 2 : len) @(posedge ref_clk_i);
        lines_o <= 4'h0;
    endtask
endmodule

// *** sim/tb_awg_trigger_replay_control.sv ***
`timescale 1ns/1ps
module tb_awg_trigger_replay_control
    import awgtr_pkg::*;
;
    logic        ref_clk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, mem_addr_o, d;
    logic [15:0] mem_data_i = 16'h0, dac_data_o, first_s;
    logic [3:0]  lines;
    logic [1:0]  filt_sel_o;
    logic        mem_rd_o, dac_valid_o, out_en_o, amp_path_o, running_o;
    int          fails = 0, cmp_count = 0, lat, cnt, k;

    always #2 ref_clk_i = ~ref_clk_i;
    // sample word tracks the address so the first sample is known
    always @(posedge ref_clk_i) mem_data_i <= mem_addr_o[15:0] + 16'h0100;

    awgtr_top #(.SWITCH_CYC(20)) awgtr_top_inst (.ref_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .trig_cmp_i(lines[0]), .multipurpose_line_one_i(lines[1]),
        .multipurpose_line_two_i(lines[2]), .multipurpose_line_three_i(lines[3]), .mem_addr_o,
        .mem_rd_o, .mem_data_i, .dac_data_o, .dac_valid_o, .out_en_o, .amp_path_o, .filt_sel_o, .running_o);
    awgtr_trig_src awgtr_trig_src_inst (.lines_o(lines), .ref_clk_i);

    // ********
    // access and compare tasks
    // ********
    task automatic test_done();
        if (fails == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        rd(a, d);
        check(d, exp);
    endtask

    // latency counted from the edge that moves the pin; 150 means no replay
    task automatic meas(input int lo, input int hi, input int n);
        lat = 0;
        cnt = 0;
        do
            @(posedge ref_clk_i) #1 lat++;
        while (dac_valid_o !== 1'b1 && lat < 150);
        first_s = dac_data_o;
        while (dac_valid_o === 1'b1 && cnt < 40)
        begin
            cnt++;
            @(posedge ref_clk_i) #1;
        end
        check(32'(lat >= lo && lat <= hi), 32'h1);
        check(32'(cnt), 32'(n));
        if (lat >= 150 && lo < 150)
            test_done();
    endtask

    task automatic run(input logic [31:0] c, input logic [3:0] m, input int len, input int lo, hi, n);
        wr(8'h04, 32'h4);
        wr(8'h00, c);
        wr(8'h04, 32'h2);
        fork
            awgtr_trig_src_inst.pulse(m, len);
            @(posedge ref_clk_i) meas(lo, hi, n);
        join
    endtask

    // ********
    // main sequence
    // ********
    initial
    begin
        repeat (12) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        rdc(8'h00, 32'h0000_0020);
        rdc(8'h14, 32'h0000_0010);
        rdc(8'h18, 32'h0000_0008);
        rdc(8'h1C, 32'h0000_03E8);
        rdc(8'h20, 32'h0000_0030);
        rdc(8'h04, 32'h0);
        rdc(8'h24, 32'h0);
        wr(8'h14, 32'h8);
        wr(8'h14, 32'h12);
        rdc(8'h14, 32'h0000_0010);
        rdc(8'h20, 32'h0000_0038);
        wr(8'h18, 32'h4);
        rdc(8'h18, 32'h0000_0008);
        wr(8'h04, 32'h8);
        run(32'h0000_1020, 4'h1, 4, 66, 66, 16);
        check(32'(first_s), 32'h0000_0100);
        check(32'(filt_sel_o), 32'h2);
        run(32'h0000_1028, 4'h1, 4, 70, 70, 16);
        run(32'h0000_1030, 4'h1, 4, 66, 66, 16);
        run(32'h0000_1020, 4'h2, 4, 150, 150, 0);
        run(32'h0000_11C3, 4'h4, 2, 66, 66, 16);
        run(32'h0000_1064, 4'h1, 4, 150, 150, 0);
        run(32'h0000_1064, 4'h3, 4, 66, 66, 16);
        wr(8'h08, 32'h5);
        run(32'h0000_1022, 4'h1, 3, 150, 150, 0);
        run(32'h0000_1022, 4'h1, 8, 68, 74, 16);
        wr(8'h0C, 32'hA);
        run(32'h0000_1025, 4'h1, 4, 76, 76, 16);
        run(32'h0000_1021, 4'h1, 4, 150, 150, 0);
        fork
            wr(8'h04, 32'h1);
            meas(1, 149, 16);
        join
        rdc(8'h20, 32'h0008_0030);
        wr(8'h10, 32'hA);
        run(32'h0000_1220, 4'h1, 4, 66, 66, 8);
        k = 0;
        do
        begin
            rd(8'h20, d);
            k++;
        end
        while (d[2:0] !== 3'h1 && k < 30);
        check(32'(k >= 5 && k <= 17), 32'h1);
        run(32'h0000_1420, 4'h1, 70, 66, 66, 10);
        wr(8'h04, 32'h4);
        wr(8'h1C, 32'h96);
        repeat (4) @(posedge ref_clk_i);
        #1 check(32'({amp_path_o, out_en_o}), 32'h0);
        repeat (25) @(posedge ref_clk_i);
        #1 check(32'(out_en_o), 32'h1);
        run(32'h0000_1020, 4'h1, 4, 66, 66, 16);
        check(32'(first_s), 32'h0000_007F);
        test_done();
    end
endmodule
